// [rtl/emb_bus.sv]
`timescale 1ns/1ps
// Functional notes
// - latch strobe high 1.5 crystal cycles, period four crystal cycles.
// - demultiplexed mode with disable clear: strobe toggles continuously.
// - strobe forced high in reset, or demultiplexed mode with disable set.
// - program store strobe pulses low during accesses, high otherwise.
// - bus mode pin sampled only at power-on reset release.
// - mode low: low port carries address then data.
// - multiplexed mode: port turns to data bus when strobe falls.
// - mode high: low port is data bus only, no address.
// - low port driven only by bus logic, never by software writes.
// - low port pins driven high while in reset.
// - high on reset input pin requests reset; wired-OR sources allowed.
// - reset output asserted when reset entered via reset input pin.
// - reset output asserted during crystal warm-up after power-on or stop.
// - reset output asserted on watchdog reset, and enabled oscillator-fail reset.
// - multiplexed mode: address low byte presented while strobe high.
module emb_bus
   import emb_pkg::*;
#(
   parameter int WARMUP_TICKS = WARMUP_TICKS_DEFAULT,
   parameter int DATA_W = 8
) (
   input wire logic sys_clk_i,
   input wire logic nrst_i,
   input wire logic reset_pin_i,
   input wire logic wdt_reset_i,
   input wire logic osc_fail_i,
   input wire logic osc_fail_reset_enable_i,
   input wire logic stop_exit_i,
   input wire logic bus_mode_select_i,
   input wire logic latch_strobe_disable_i,
   input wire logic acc_req_i,
   input wire logic [DATA_W-1:0] acc_addr_i,
   output logic acc_take_o,
   output logic acc_ack_o,
   output logic [DATA_W-1:0] acc_rdata_o,
   input wire logic [DATA_W-1:0] ad_i,
   output logic [DATA_W-1:0] ad_o,
   output logic ad_oe_o,
   output logic ale_o,
   output logic program_store_strobe_o,
   output logic reset_out_n_o,
   output logic bus_mode_o
);
   // refused at elaboration: the port is one byte wide and warm-up needs a nonzero count
   if (DATA_W != 8) begin : g_bad_width
      $error("emb_bus: DATA_W must be 8");
   end
   if (WARMUP_TICKS < 1) begin : g_bad_warmup
      $error("emb_bus: WARMUP_TICKS must be at least 1");
   end

   localparam int PW = $clog2(ALE_PERIOD_TICKS);
   localparam int WW = $clog2(WARMUP_TICKS + 1);

   // phase decode, shared by both strobes and the low port
   function automatic logic in_range(input logic [PW-1:0] p, input int lo, input int hi);
      in_range = (int'(p) >= lo) && (int'(p) <= hi);
   endfunction : in_range

   logic por_pending;
   logic [WW-1:0] warm_cnt;
   logic warming;
   logic in_reset;
   logic [PW-1:0] phase;
   logic phase_last;
   emb_state_t state;
   logic [DATA_W-1:0] addr;

   // crystal warm-up runs after power-on release and after leaving stop mode
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         warm_cnt <= WW'(WARMUP_TICKS);
      end else if (stop_exit_i) begin
         warm_cnt <= WW'(WARMUP_TICKS);
      end else if (warm_cnt != '0) begin
         warm_cnt <= warm_cnt - 1'b1;
      end
   end
   assign warming = (warm_cnt != '0);

   // every reset source stops the bus; pin is a wired-OR level
   assign in_reset = reset_pin_i || wdt_reset_i || (osc_fail_i && osc_fail_reset_enable_i)
                     || warming;

   // reset output, registered so it never glitches on the pin
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         reset_out_n_o <= 1'b0;
      end else begin
         reset_out_n_o <= !(reset_pin_i || warming || wdt_reset_i
                            || (osc_fail_i && osc_fail_reset_enable_i));
      end
   end

   // mode strap caught once, at the first edge after power-on release
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         por_pending <= 1'b1;
         bus_mode_o <= MODE_RESET_VALUE;
      end else if (por_pending) begin
         por_pending <= 1'b0;
         bus_mode_o <= bus_mode_select_i;
      end
   end

   emb_phase #(
      .PERIOD(ALE_PERIOD_TICKS)
   ) u_phase (
      .sys_clk_i(sys_clk_i),
      .nrst_i(nrst_i),
      .hold_i(in_reset),
      .phase_o(phase),
      .last_o(phase_last)
   );

   // a request is taken only on the last phase, so each access owns a whole period
   assign acc_take_o = acc_req_i && phase_last && !in_reset && !por_pending;

   // access sequencer; a new take at the last phase chains directly to the next access
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state <= EMB_IDLE;
         addr <= '0;
      end else if (in_reset) begin
         state <= EMB_IDLE;
      end else if (phase_last) begin
         state <= acc_take_o ? EMB_BUSY : EMB_IDLE;
         if (acc_take_o) begin
            addr <= acc_addr_i;
         end
      end
   end

   // read data sampled at the end of the strobe-low window, with a one-cycle ack
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         acc_ack_o <= 1'b0;
         acc_rdata_o <= '0;
      end else begin
         acc_ack_o <= (state == EMB_BUSY) && phase_last;
         if ((state == EMB_BUSY) && phase_last) begin
            acc_rdata_o <= ad_i;
         end
      end
   end

   // latch strobe: three half-cycle ticks high out of eight; a strobe let go from a hold
   // stays high until the next fall point, so no short low period follows the release
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ale_o <= 1'b1;
      end else if (in_reset) begin
         ale_o <= 1'b1;
      end else if (bus_mode_o && latch_strobe_disable_i) begin
         ale_o <= 1'b1;
      end else begin
         ale_o <= in_range(phase, 0, ALE_HIGH_TICKS - 1)
                  || (ale_o && !in_range(phase, ALE_HIGH_TICKS, ALE_HIGH_TICKS));
      end
   end

   // program store strobe low only inside a live access, after the address phase
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         program_store_strobe_o <= 1'b1;
      end else begin
         program_store_strobe_o <= !(!in_reset && state == EMB_BUSY
                                     && in_range(phase, PSTR_FIRST_PHASE,
                                                 PSTR_LAST_PHASE));
      end
   end

   // low port: no software path exists; only reset and the sequencer drive it
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ad_o <= PORT_RESET_VALUE;
         ad_oe_o <= 1'b1;
      end else case (1'b1)
         in_reset: begin
            ad_o <= PORT_RESET_VALUE;
            ad_oe_o <= 1'b1;
         end
         (!bus_mode_o && state == EMB_BUSY
          && in_range(phase, 0, ALE_HIGH_TICKS - 1)): begin
            ad_o <= addr;
            ad_oe_o <= 1'b1;
         end
         default: begin
            // released as data bus from strobe fall; demux never carries address
            ad_o <= ad_o;
            ad_oe_o <= 1'b0;
         end
      endcase
   end
endmodule : emb_bus

// [rtl/emb_phase.sv]
`timescale 1ns/1ps
// free-running half-cycle phase counter that paces the latch strobe and accesses
module emb_phase
   import emb_pkg::*;
#(
   parameter int PERIOD = ALE_PERIOD_TICKS
) (
   input wire logic sys_clk_i,
   input wire logic nrst_i,
   input wire logic hold_i,
   output logic [$clog2(PERIOD)-1:0] phase_o,
   output logic last_o
);
   // refused at elaboration: the strobe and access windows need at least four phases
   if (PERIOD < 4) begin : g_bad_period
      $error("emb_phase: PERIOD too small");
   end

   localparam logic [$clog2(PERIOD)-1:0] LAST = ($clog2(PERIOD))'(PERIOD - 1);

   // held at zero in reset so the first strobe after release starts cleanly
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         phase_o <= '0;
      end else if (hold_i || phase_o == LAST) begin
         phase_o <= '0;
      end else begin
         phase_o <= phase_o + 1'b1;
      end
   end

   assign last_o = (phase_o == LAST) && !hold_i;
endmodule : emb_phase

// [rtl/emb_pkg.sv]
package emb_pkg;
   // the system clock ticks once per half crystal-input cycle
   localparam int HALF_TICKS_PER_XTAL = 2;
   // latch strobe period and high width, in crystal-input cycles (x2 for half cycles)
   localparam int ALE_PERIOD_XTAL = 4;
   localparam real ALE_HIGH_XTAL = 1.5;
   localparam int ALE_PERIOD_TICKS = ALE_PERIOD_XTAL * HALF_TICKS_PER_XTAL;
   localparam int ALE_HIGH_TICKS = int'(ALE_HIGH_XTAL * HALF_TICKS_PER_XTAL);
   // program store strobe low window, in ticks of the phase counter
   localparam int PSTR_FIRST_PHASE = 4;
   localparam int PSTR_LAST_PHASE = 6;
   // crystal warm-up length in ticks; no figure is given, plain default
   localparam int WARMUP_TICKS_DEFAULT = 1024;
   // reset values
   localparam logic [7:0] PORT_RESET_VALUE = 8'hFF;
   localparam logic MODE_RESET_VALUE = 1'b0;
   // access sequencer states
   typedef enum logic {EMB_IDLE, EMB_BUSY} emb_state_t;
endpackage : emb_pkg

// [testbench/emb_bus_sva.sv]
`timescale 1ns/1ps
// bus pin checks; most pause while any reset source or the strobe hold is active
module emb_bus_sva #(parameter int DATA_W = 8) (
   input wire logic sys_clk_i,
   input wire logic nrst_i,
   input wire logic reset_pin_i,
   input wire logic wdt_reset_i,
   input wire logic osc_fail_i,
   input wire logic stop_exit_i,
   input wire logic latch_strobe_disable_i,
   input wire logic acc_take_o,
   input wire logic acc_ack_o,
   input wire logic [DATA_W-1:0] acc_addr_i,
   input wire logic [DATA_W-1:0] ad_o,
   input wire logic ad_oe_o,
   input wire logic ale_o,
   input wire logic program_store_strobe_o,
   input wire logic reset_out_n_o,
   input wire logic bus_mode_o
);
   logic calm;
   // reset lags its cause by a cycle, so the sources themselves gate the timing checks
   assign calm = reset_out_n_o & ~reset_pin_i & ~wdt_reset_i & ~osc_fail_i & ~stop_exit_i
      & ~(bus_mode_o & latch_strobe_disable_i);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!nrst_i || !calm);
   chk_ale_high_width: assert property ($rose(ale_o) |-> ale_o[*3] ##1 !ale_o)
      else $error("strobe high width wrong");
   chk_ale_low_width: assert property ($fell(ale_o) |-> !ale_o[*5] ##1 ale_o)
      else $error("strobe period wrong");
   // the previous access's ack may still show one sample after a chained take; its strobe is already high
   chk_fetch_ack: assert property (acc_take_o |-> ##2 (!acc_ack_o)[*7] ##1 acc_ack_o)
      else $error("ack not nine cycles after take");
   chk_strobe_window: assert property (acc_take_o |-> ##1 program_store_strobe_o[*5]
      ##1 (!program_store_strobe_o)[*3] ##1 program_store_strobe_o) else $error("strobe window");
   chk_addr_phase: assert property (acc_take_o && !bus_mode_o |-> ##2
      (ale_o && ad_oe_o && ad_o == $past(acc_addr_i, 2)) ##1 (ale_o && ad_oe_o && $stable(ad_o))[*2]
      ##1 (!ale_o && !ad_oe_o)) else $error("address phase wrong");
   chk_demux_no_addr: assert property (bus_mode_o |-> !ad_oe_o)
      else $error("port driven in demux mode");
   chk_pin_reset: assert property (disable iff (!nrst_i) reset_pin_i[*2]
      |-> !reset_out_n_o && ale_o && ad_oe_o && ad_o == '1) else $error("pin reset pins");
   chk_wdt_reset: assert property (disable iff (!nrst_i) wdt_reset_i[*2] |-> !reset_out_n_o)
      else $error("watchdog reset out");
   chk_mode_kept: assert property (disable iff (!nrst_i) $past(nrst_i, 2) |-> $stable(bus_mode_o))
      else $error("bus mode changed");
   chk_demux_hold: assert property (disable iff (!nrst_i) bus_mode_o && latch_strobe_disable_i
      && $past(latch_strobe_disable_i) |-> ale_o) else $error("strobe not held");
endmodule : emb_bus_sva

// [testbench/emb_mem_model.sv]
`timescale 1ns/1ps
// external memory behind a transparent address latch; byte = latched address ^ 5A
module emb_mem_model (
   input wire logic sys_clk_i,
   input wire logic ale_i,
   input wire logic pss_n_i,
   input wire logic [7:0] ad_i,
   output logic oe_o,
   output logic [7:0] d_o
);
   logic [7:0] addr_q = 8'h00;
   // latch follows the port while the strobe is high
   always @(posedge sys_clk_i) if (ale_i) addr_q <= ad_i;
   assign oe_o = !pss_n_i;
   assign d_o = addr_q ^ 8'h5A;
endmodule : emb_mem_model

// [testbench/tb.sv]
`timescale 1ns/1ps
module tb;
   import emb_pkg::*;
   logic sys_clk_i = 0, nrst_i = 0, reset_pin_i = 0, wdt_reset_i = 0, osc_fail_i = 0;
   logic osc_fail_reset_enable_i = 1, stop_exit_i = 0, bus_mode_select_i = 0;
   logic latch_strobe_disable_i = 0, acc_req_i = 0, p;
   logic [7:0] acc_addr_i = 8'h00, ad_i, ad_o, acc_rdata_o, mem_d, last = 8'h00;
   logic acc_take_o, acc_ack_o, ad_oe_o, ale_o, program_store_strobe_o, reset_out_n_o;
   logic bus_mode_o, mem_oe;
   int mismatches = 0, samples_checked = 0, n;
   always #2.5 sys_clk_i = ~sys_clk_i;
   emb_bus #(
      .WARMUP_TICKS(4),
      .DATA_W(8)
   ) DUT (
      .sys_clk_i(sys_clk_i),
      .nrst_i(nrst_i),
      .reset_pin_i(reset_pin_i),
      .wdt_reset_i(wdt_reset_i),
      .osc_fail_i(osc_fail_i),
      .osc_fail_reset_enable_i(osc_fail_reset_enable_i),
      .stop_exit_i(stop_exit_i),
      .bus_mode_select_i(bus_mode_select_i),
      .latch_strobe_disable_i(latch_strobe_disable_i),
      .acc_req_i(acc_req_i),
      .acc_addr_i(acc_addr_i),
      .acc_take_o(acc_take_o),
      .acc_ack_o(acc_ack_o),
      .acc_rdata_o(acc_rdata_o),
      .ad_i(ad_i),
      .ad_o(ad_o),
      .ad_oe_o(ad_oe_o),
      .ale_o(ale_o),
      .program_store_strobe_o(program_store_strobe_o),
      .reset_out_n_o(reset_out_n_o),
      .bus_mode_o(bus_mode_o)
   );
   emb_mem_model u_mem (.sys_clk_i(sys_clk_i), .ale_i(ale_o), .pss_n_i(program_store_strobe_o),
      .ad_i(ad_i), .oe_o(mem_oe), .d_o(mem_d));
   // no pull-ups: a released port shows the inverse of its last level
   assign ad_i = ad_oe_o ? ad_o : (mem_oe ? mem_d : ~last);
   always @(posedge sys_clk_i) last <= ad_i;
   task tick; @(posedge sys_clk_i); #1; endtask : tick
   task chk(input logic ok, input string m);
      samples_checked++;
      if (ok !== 1'b1) begin mismatches++; $display("CHECK FAILED %0t %s", $time, m); end
   endtask : chk
   // a reset output that never lets go is a failure, not a silent pass
   task wait_up;
      n = 0;
      while (reset_out_n_o !== 1'b1 && n < 60) begin
         tick;
         n++;
      end
      chk(reset_out_n_o === 1'b1, "reset stuck");
   endtask : wait_up
   task boot(input logic mode);
      nrst_i = 0; bus_mode_select_i = mode;
      repeat (4) tick;
      chk(ale_o && ad_oe_o && ad_o === 8'hFF && !reset_out_n_o, "reset pins");
      nrst_i = 1; tick; bus_mode_select_i = !mode; wait_up;
      chk(bus_mode_o === mode, "strap");
   endtask : boot
   task fetch(input logic [7:0] a);
      n = 0; acc_addr_i = a; acc_req_i = 1;
      while (acc_take_o !== 1'b1 && n < 20) begin tick; n++; end
      tick; acc_req_i = 0; n = 0;
      while (acc_ack_o !== 1'b1 && n < 12) begin tick; n++; end
      chk(acc_ack_o === 1'b1, "no ack");
   endtask : fetch
   task t_mux;
      boot(0); fetch(8'h00); chk(acc_rdata_o === 8'h5A, "data 00");
      fetch(8'hFF); chk(acc_rdata_o === 8'hA5, "data FF");
      $display("mux fetch test done");
   endtask : t_mux
   task t_resets;
      for (int i = 0; i < 4; i++) begin
         reset_pin_i = i == 0; wdt_reset_i = i == 1; osc_fail_i = i > 1;
         osc_fail_reset_enable_i = i == 2; repeat (3) tick;
         chk(reset_out_n_o === logic'(i == 3), "reset out");
         reset_pin_i = 0; wdt_reset_i = 0; osc_fail_i = 0; tick; wait_up;
      end
      stop_exit_i = 1; tick; stop_exit_i = 0; tick;
      chk(reset_out_n_o === 1'b0, "warm-up");
      wait_up; $display("reset source test done");
   endtask : t_resets
   task t_demux;
      boot(1); n = 0;
      repeat (16) begin p = ale_o; tick; if (ale_o && !p) n++; end
      chk(n == 2, "toggle count");
      while (ale_o !== 1'b1) tick;
      latch_strobe_disable_i = 1;
      repeat (12) begin tick; chk(ale_o === 1'b1, "strobe held"); end
      latch_strobe_disable_i = 0; fetch(8'h3C);
      $display("demux test done");
   endtask : t_demux
   task test_done;
      $display("mismatches %0d checks %0d", mismatches, samples_checked);
      if (mismatches == 0 && samples_checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : test_done
   initial begin t_mux; t_resets; t_demux; test_done; end
   // the tests need well under a thousand ns; this cuts a hang short
   initial begin #20000; mismatches++; test_done; end
endmodule : tb
bind emb_bus emb_bus_sva #(
   .DATA_W(DATA_W)
) u_sva (
   .sys_clk_i(sys_clk_i),
   .nrst_i(nrst_i),
   .reset_pin_i(reset_pin_i),
   .wdt_reset_i(wdt_reset_i),
   .osc_fail_i(osc_fail_i),
   .stop_exit_i(stop_exit_i),
   .latch_strobe_disable_i(latch_strobe_disable_i),
   .acc_take_o(acc_take_o),
   .acc_ack_o(acc_ack_o),
   .acc_addr_i(acc_addr_i),
   .ad_o(ad_o),
   .ad_oe_o(ad_oe_o),
   .ale_o(ale_o),
   .program_store_strobe_o(program_store_strobe_o),
   .reset_out_n_o(reset_out_n_o),
   .bus_mode_o(bus_mode_o)
);
